// ===== ep_pkg.sv
/*
 * Shared constants and carrier types for the eight-bit port whose upper three pins
 * (5 to 7) carry the parallel-port strobes, PWM channels and analog inputs.
 * Assumes a single 40 MHz clock domain and a plain register port with a three-bit word address.
 */
package ep_pkg;

  localparam int unsigned EP_PIN_W = 8;
  localparam int unsigned EP_ADDR_W = 3;

  // Register word offsets on the plain register port.
  localparam logic [2:0] EP_OFF_PIN_LEVEL = 3'h0;
  localparam logic [2:0] EP_OFF_OUT_LATCH = 3'h1;
  localparam logic [2:0] EP_OFF_DIRECTION = 3'h2;
  localparam logic [2:0] EP_OFF_SHARED = 3'h3;
  localparam logic [2:0] EP_OFF_WDT_CTRL = 3'h4;
  localparam logic [2:0] EP_OFF_PWM_TRI = 3'h5;

  // Field positions.
  localparam int unsigned EP_WDT_SHARED_BIT = 4;
  localparam int unsigned EP_PIN5 = 5;
  localparam int unsigned EP_PIN6 = 6;
  localparam int unsigned EP_PIN7 = 7;
  localparam int unsigned EP_TRI_P3B = 0;
  localparam int unsigned EP_TRI_P1C = 1;
  localparam int unsigned EP_TRI_P1B = 2;

  // Analog select: a 0 bit means analog, bits 7:2 map to channels 15 down to 10.
  localparam logic [7:0] EP_ANALOG_IMPL_MASK = 8'hfc;

  // Values after reset.
  localparam logic [7:0] EP_RST_LATCH = 8'h00;
  localparam logic [7:0] EP_RST_DIRECTION = 8'hff;
  localparam logic [7:0] EP_RST_ANALOG = 8'h00;
  localparam logic [7:0] EP_RST_WDT = 8'h00;
  localparam logic [7:0] EP_RST_DEFAULT = 8'h00;
  localparam logic [2:0] EP_RST_PWM_TRI = 3'h0;
  localparam logic [7:0] EP_READ_ZERO = 8'h00;

  // PWM channel values and their per-channel enables from the PWM modules.
  typedef struct packed {
    logic p1b;
    logic p1c;
    logic p3b;
    logic p3c;
  } ep_pwm_t;

  // Parallel-port unit signals toward the pins.
  typedef struct packed {
    logic enable;
    logic master;
    logic byte_enable;
    logic read_strobe;
    logic write_strobe;
  } ep_par_t;

endpackage

// ===== ep_sync2.sv
/*
 * Two-flop synchroniser bank for the port pin levels.
 * Assumes the inputs are asynchronous pins and that only the second stage is read downstream.
 */
`timescale 1ns/1ps
module ep_sync2
  import ep_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [EP_PIN_W-1:0] async_i,
  output logic [EP_PIN_W-1:0] sync_o
);

  logic [EP_PIN_W-1:0] meta_r;
  logic [EP_PIN_W-1:0] sync_r;

  // The first stage feeds only the second stage, so a metastable sample never fans out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= EP_READ_ZERO;
      sync_r <= EP_READ_ZERO;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// ===== ep_port_top.sv
/*
 * Eight-bit bidirectional port with the pin 5 to 7 alternate functions: parallel-port
 * byte enable and strobes, PWM channels with optional tri-state on shutdown, and analog inputs.
 * Assumes the PWM and parallel-port units run on clk_i and that the package size strap is static.
 */
// Decided for this implementation: the register addresses and the strobed register port.
//
// Contract
// (R1) Peripherals with don't-care direction override the direction bit and set pin direction.
// (R2) Reset makes pins 5..7 analog channels 13..15; digital driver stays enabled.
// (R3) Mapped PWM with direction 0 beats latch and parallel-port data.
// (R4) Each mapped PWM output may float during a PWM shutdown event; P3C on the other port never floats.
// (R5) PWM B/C of modules 1 and 3 land here only when alt map clear.
// (R6) Map select 0 puts parallel byte enable on pin 5 regardless of direction.
// (R7) Map select 0: pin 6 is read strobe, driven as master, input as slave.
// (R8) Map select 0: pin 7 is write strobe, driven as master, input as slave.
// (R9) Small package: level, latch and direction registers read as zero.
// (R10) Shared address holds analog select only while watchdog control bit 4 is 1.
// (R11) Analog select bits 7:2 pick analog or digital for channels 15 down to 10.
// (R12) Plain mode drives latch when direction 0; reads buffered pin when direction 1.
// (R13) Writing the level register updates the latch; reading returns pin levels.
`timescale 1ns/1ps
module ep_port_top
  import ep_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [EP_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [EP_PIN_W-1:0] pin_i,
  output logic [EP_PIN_W-1:0] pin_o,
  output logic [EP_PIN_W-1:0] pin_oe_o,
  input wire logic small_package_i,
  input wire logic pwm_alt_map_select_i,
  input wire ep_pwm_t pwm_val_i,
  input wire ep_pwm_t pwm_en_i,
  input wire logic pwm_shutdown_i,
  input wire logic par_port_map_select_i,
  input wire ep_par_t par_i,
  output logic par_read_strobe_o,
  output logic par_write_strobe_o,
  output logic [3:0] other_port_e_pins_o,
  output logic [3:0] other_port_e_pins_oe_o,
  output logic [2:0] analog_ch_en_o
);

  logic [7:0] latch_r;
  logic [7:0] dir_r;
  logic [7:0] analog_r;
  logic [7:0] wdt_r;
  logic [7:0] default_r;
  logic [2:0] pwm_tri_r;
  logic small_r;
  logic [7:0] rdata_r;
  logic [EP_PIN_W-1:0] pin_r;
  logic [EP_PIN_W-1:0] pin_oe_r;
  logic [3:0] other_port_e_pins_r;
  logic [3:0] other_port_e_pins_oe_r;
  logic par_rd_in_r;
  logic par_wr_in_r;
  logic [EP_PIN_W-1:0] pin_sync;
  logic shared_alt;
  logic pwm_here;
  logic par_here;
  logic [7:0] pin_read;
  logic [7:0] digital_in;
  logic [7:0] pwm_sel;
  logic [7:0] pwm_val;
  logic [7:0] pwm_float;
  logic [7:0] par_sel;
  logic [7:0] par_val;
  logic [7:0] par_drive;
  logic [EP_PIN_W-1:0] pin_nxt;
  logic [EP_PIN_W-1:0] pin_oe_nxt;

  ep_sync2 u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  // The package strap is caught while reset is held and frozen after release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      small_r <= small_package_i;
    end
  end

  assign shared_alt = wdt_r[EP_WDT_SHARED_BIT]; // (R10)
  assign pwm_here = ~pwm_alt_map_select_i; // (R5)
  assign par_here = par_i.enable & (par_port_map_select_i == 1'b0);

  // Pins set as analog read back as zero on the digital path.
  assign digital_in = pin_sync & (analog_r | ~EP_ANALOG_IMPL_MASK); // (R11)
  assign pin_read = small_r ? EP_READ_ZERO : digital_in; // (R9) (R13)

  // Output latch: written through either the level or the latch address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_r <= EP_RST_LATCH;
    end else if (wr_i && (addr_i == EP_OFF_PIN_LEVEL || addr_i == EP_OFF_OUT_LATCH)) begin
      latch_r <= wdata_i; // (R13)
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_r <= EP_RST_DIRECTION;
    end else if (wr_i && addr_i == EP_OFF_DIRECTION) begin
      dir_r <= wdata_i;
    end
  end

  // Analog select resets to all-analog, so pins 5..7 come up as channels 13..15.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_r <= EP_RST_ANALOG; // (R2)
    end else if (wr_i && addr_i == EP_OFF_SHARED && shared_alt) begin
      analog_r <= wdata_i & EP_ANALOG_IMPL_MASK; // (R10) (R11)
    end
  end

  // The default register behind the shared address is only reachable while bit 4 is clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      default_r <= EP_RST_DEFAULT;
    end else if (wr_i && addr_i == EP_OFF_SHARED && !shared_alt) begin
      default_r <= wdata_i; // (R10)
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_r <= EP_RST_WDT;
    end else if (wr_i && addr_i == EP_OFF_WDT_CTRL) begin
      wdt_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_tri_r <= EP_RST_PWM_TRI;
    end else if (wr_i && addr_i == EP_OFF_PWM_TRI) begin
      pwm_tri_r <= wdata_i[2:0]; // (R4)
    end
  end

  // Read data stand for exactly the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= EP_READ_ZERO;
    end else if (rd_i) begin
      unique case (addr_i)
        EP_OFF_PIN_LEVEL: rdata_r <= pin_read; // (R13)
        EP_OFF_OUT_LATCH: rdata_r <= small_r ? EP_READ_ZERO : latch_r; // (R9)
        EP_OFF_DIRECTION: rdata_r <= small_r ? EP_READ_ZERO : dir_r; // (R9)
        EP_OFF_SHARED: rdata_r <= shared_alt ? analog_r : default_r; // (R10)
        EP_OFF_WDT_CTRL: rdata_r <= wdt_r;
        EP_OFF_PWM_TRI: rdata_r <= {5'h00, pwm_tri_r};
        default: rdata_r <= EP_READ_ZERO;
      endcase
    end else begin
      rdata_r <= EP_READ_ZERO;
    end
  end

  // PWM overrides for pins 5..7; the direction bit must be 0 for the PWM to claim the pin.
  always_comb begin
    pwm_sel = 8'h00;
    pwm_val = 8'h00;
    pwm_float = 8'h00;
    pwm_sel[EP_PIN5] = pwm_here & pwm_en_i.p3b & ~dir_r[EP_PIN5]; // (R3) (R5)
    pwm_sel[EP_PIN6] = pwm_here & pwm_en_i.p1c & ~dir_r[EP_PIN6]; // (R3) (R5)
    pwm_sel[EP_PIN7] = pwm_here & pwm_en_i.p1b & ~dir_r[EP_PIN7]; // (R3) (R5)
    pwm_val[EP_PIN5] = pwm_val_i.p3b;
    pwm_val[EP_PIN6] = pwm_val_i.p1c;
    pwm_val[EP_PIN7] = pwm_val_i.p1b;
    pwm_float[EP_PIN5] = pwm_shutdown_i & pwm_tri_r[EP_TRI_P3B]; // (R4)
    pwm_float[EP_PIN6] = pwm_shutdown_i & pwm_tri_r[EP_TRI_P1C]; // (R4)
    pwm_float[EP_PIN7] = pwm_shutdown_i & pwm_tri_r[EP_TRI_P1B]; // (R4)
  end

  // Parallel-port claims ignore the direction bit; the strobes float when the port is a slave.
  always_comb begin
    par_sel = 8'h00;
    par_val = 8'h00;
    par_drive = 8'h00;
    par_sel[EP_PIN5] = par_here; // (R1) (R6)
    par_sel[EP_PIN6] = par_here; // (R1) (R7)
    par_sel[EP_PIN7] = par_here; // (R1) (R8)
    par_val[EP_PIN5] = par_i.byte_enable;
    par_val[EP_PIN6] = par_i.read_strobe;
    par_val[EP_PIN7] = par_i.write_strobe;
    par_drive[EP_PIN5] = 1'b1; // (R6)
    par_drive[EP_PIN6] = par_i.master; // (R7)
    par_drive[EP_PIN7] = par_i.master; // (R8)
  end

  // Per-pin priority: PWM, then parallel port, then the plain latch and direction.
  // Analog selection leaves the digital driver alone, so an analog pin with direction 0 still drives.
  for (genvar i = 0; i < EP_PIN_W; i++) begin : g_pin
    always_comb begin
      if (small_r) begin
        pin_nxt[i] = 1'b0;
        pin_oe_nxt[i] = 1'b0;
      end else if (pwm_sel[i]) begin
        pin_nxt[i] = pwm_val[i]; // (R3)
        pin_oe_nxt[i] = ~pwm_float[i]; // (R4)
      end else if (par_sel[i]) begin
        pin_nxt[i] = par_val[i]; // (R1)
        pin_oe_nxt[i] = par_drive[i]; // (R1)
      end else begin
        pin_nxt[i] = latch_r[i]; // (R12)
        pin_oe_nxt[i] = ~dir_r[i]; // (R12) (R2)
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_r <= EP_READ_ZERO;
      pin_oe_r <= EP_READ_ZERO;
    end else begin
      pin_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  // With the alternate map set, the four PWM channels go to the other port instead.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      other_port_e_pins_r <= 4'h0;
      other_port_e_pins_oe_r <= 4'h0;
    end else begin
      other_port_e_pins_r <= pwm_val_i; // (R5)
      other_port_e_pins_oe_r <= pwm_alt_map_select_i ? (pwm_en_i & ~({4{pwm_shutdown_i}} &
        {pwm_tri_r[EP_TRI_P1B], pwm_tri_r[EP_TRI_P1C], pwm_tri_r[EP_TRI_P3B], 1'b0})) : 4'h0; // (R5) (R4)
    end
  end

  // Slave-mode strobes come in on the synchronised pins; they read low unless the port is a mapped slave.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      par_rd_in_r <= 1'b0;
      par_wr_in_r <= 1'b0;
    end else begin
      par_rd_in_r <= par_here & ~par_i.master & pin_sync[EP_PIN6]; // (R7)
      par_wr_in_r <= par_here & ~par_i.master & pin_sync[EP_PIN7]; // (R8)
    end
  end

  assign rdata_o = rdata_r;
  assign pin_o = pin_r;
  assign pin_oe_o = pin_oe_r;
  assign other_port_e_pins_o = other_port_e_pins_r;
  assign other_port_e_pins_oe_o = other_port_e_pins_oe_r;
  assign par_read_strobe_o = par_rd_in_r;
  assign par_write_strobe_o = par_wr_in_r;
  assign analog_ch_en_o = ~analog_r[EP_PIN7:EP_PIN5]; // (R2) (R11)

endmodule

// ===== ep_port_chk.sv
/* Checker for the upper pin mux of the port, seeing only the top ports.
   Assumes one clock domain and the strap sampled only in reset. */
`timescale 1ns/1ps
module ep_port_chk
  import ep_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [EP_ADDR_W-1:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [EP_PIN_W-1:0] pin_o,
  input wire logic [EP_PIN_W-1:0] pin_oe_o,
  input wire logic small_package_i,
  input wire logic pwm_alt_map_select_i,
  input wire ep_pwm_t pwm_en_i,
  input wire logic pwm_shutdown_i,
  input wire logic par_port_map_select_i,
  input wire ep_par_t par_i,
  input wire logic [3:0] other_port_e_pins_oe_o,
  input wire logic [2:0] analog_ch_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic small_r;
  logic par_on;
  logic pwm_here;
  // The strap is frozen after reset, so only reset cycles update the copy.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      small_r <= small_package_i;
    end
  end
  assign par_on = !par_port_map_select_i && par_i.enable && !small_r;
  assign pwm_here = !pwm_alt_map_select_i;
  property p_por_analog;
    $fell(rst_i) |-> analog_ch_en_o == 3'h7;
  endproperty
  a_por_analog: assert property (p_por_analog) else $error("pins not analog after reset");
  property p_byte_en;
    par_on && !(pwm_here && pwm_en_i.p3b) |=> pin_oe_o[5] && pin_o[5] == $past(par_i.byte_enable);
  endproperty
  a_byte_en: assert property (p_byte_en) else $error("byte enable not on pin 5");
  property p_rd_master;
    par_on && par_i.master && !(pwm_here && pwm_en_i.p1c) |=> pin_oe_o[6] && pin_o[6] == $past(par_i.read_strobe);
  endproperty
  a_rd_master: assert property (p_rd_master) else $error("read strobe not driven");
  property p_wr_master;
    par_on && par_i.master && !(pwm_here && pwm_en_i.p1b) |=> pin_oe_o[7] && pin_o[7] == $past(par_i.write_strobe);
  endproperty
  a_wr_master: assert property (p_wr_master) else $error("write strobe not driven");
  property p_slave;
    par_on && !par_i.master && !(pwm_here && (pwm_en_i.p1c || pwm_en_i.p1b)) |=> pin_oe_o[7:6] == 2'b00;
  endproperty
  a_slave: assert property (p_slave) else $error("slave strobe pin driven");
  property p_alt_map;
    !pwm_here && !pwm_shutdown_i |=> other_port_e_pins_oe_o == $past(pwm_en_i);
  endproperty
  a_alt_map: assert property (p_alt_map) else $error("alternate pwm pins wrong");
  property p_small_pins;
    small_r |=> pin_oe_o[7:5] == 3'h0;
  endproperty
  a_small_pins: assert property (p_small_pins) else $error("small package drives pins");
  property p_small_read;
    small_r && rd_i && addr_i <= EP_OFF_DIRECTION |=> rdata_o == 8'h00;
  endproperty
  a_small_read: assert property (p_small_read) else $error("small package read not zero");
endmodule

bind ep_port_top ep_port_chk u_ep_port_chk(.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .small_package_i(small_package_i),
  .pwm_alt_map_select_i(pwm_alt_map_select_i), .pwm_en_i(pwm_en_i), .pwm_shutdown_i(pwm_shutdown_i),
  .par_port_map_select_i(par_port_map_select_i), .par_i(par_i),
  .other_port_e_pins_oe_o(other_port_e_pins_oe_o), .analog_ch_en_o(analog_ch_en_o));

// ===== ep_pin_model.sv
/* External circuitry on the port pins.
   Assumes drv_oe_i high means the device drives; lines nobody drives toggle. */
`timescale 1ns/1ps
module ep_pin_model
  import ep_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [EP_PIN_W-1:0] drv_i,
  input wire logic [EP_PIN_W-1:0] drv_oe_i,
  input wire logic [EP_PIN_W-1:0] ext_val_i,
  input wire logic [EP_PIN_W-1:0] ext_en_i,
  output logic [EP_PIN_W-1:0] pin_o
);
  logic tgl_r;
  // A floating line toggles so that a stale level is never mistaken for data.
  always_ff @(posedge clk_i) begin
    tgl_r <= rst_i ? 1'b0 : ~tgl_r;
  end
  // Slave strobes on pins 6 and 7 come from the external party here.
  assign pin_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_en_i & ext_val_i)
    | (~drv_oe_i & ~ext_en_i & {EP_PIN_W{tgl_r}});
endmodule

// ===== testbench.sv
/* Self-checking bench for the port: register tasks and pin mux scenarios.
   Assumes the design, the checker and ep_pin_model are compiled first. */
`timescale 1ns/1ps
module testbench
  import ep_pkg::*;
;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sml = 0, alt = 0, sd = 0, pmap = 0, rs, ws;
  logic [2:0] addr_i = 0, ana;
  logic [7:0] wdata_i = 0, rdata_o, pin_i, pin_o, pin_oe, ext_val = 0, ext_en = 0;
  logic [3:0] e_pins, e_oe;
  ep_pwm_t pval = 0, pen = 0;
  ep_par_t par = 0;
  int n_errors = 0, n_tests = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  ep_port_top u_ep_port_top(.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .small_package_i(sml),
    .pwm_alt_map_select_i(alt), .pwm_val_i(pval), .pwm_en_i(pen), .pwm_shutdown_i(sd),
    .par_port_map_select_i(pmap), .par_i(par), .par_read_strobe_o(rs), .par_write_strobe_o(ws),
    .other_port_e_pins_o(e_pins), .other_port_e_pins_oe_o(e_oe), .analog_ch_en_o(ana));
  ep_pin_model u_ep_pin_model(.clk_i(clk_i), .rst_i(rst_i), .drv_i(pin_o), .drv_oe_i(pin_oe),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pin_i));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
  endtask
  task automatic do_reset(input logic s);
    rst_i <= 1'b1;
    sml <= s;
    tick(16);
    rst_i <= 1'b0;
  endtask
  initial begin
    do_reset(1'b0);
    chk("analog", 8'h07, {5'h0, ana});
    rd(EP_OFF_DIRECTION, EP_RST_DIRECTION, "dir");
    wr(EP_OFF_DIRECTION, 8'h00);
    wr(EP_OFF_PIN_LEVEL, 8'ha5);
    rd(EP_OFF_OUT_LATCH, 8'ha5, "latch");
    tick(4);
    chk("oe_analog", 8'hff, pin_oe);
    rd(EP_OFF_PIN_LEVEL, 8'h01, "level_analog");
    wr(EP_OFF_WDT_CTRL, 8'h10);
    wr(EP_OFF_SHARED, 8'hff);
    rd(EP_OFF_SHARED, 8'hfc, "analog_sel");
    chk("digital", 8'h00, {5'h0, ana});
    rd(EP_OFF_PIN_LEVEL, 8'ha5, "level");
    wr(EP_OFF_DIRECTION, 8'hff);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    tick(4);
    rd(EP_OFF_PIN_LEVEL, 8'h3c, "level_in");
    rd(3'h7, 8'h00, "unmapped");
    wr(EP_OFF_WDT_CTRL, 8'h00);
    wr(EP_OFF_SHARED, 8'h5a);
    rd(EP_OFF_SHARED, 8'h5a, "default_reg");
    chk("digital_kept", 8'h00, {5'h0, ana});
    $display("register test done");
    wr(EP_OFF_DIRECTION, 8'h00);
    par <= 5'b11110;
    pval <= 4'b0100;
    pen <= 4'hf;
    tick(3);
    chk("pwm_pins", 8'h02, {5'h0, pin_o[7:5]});
    sd <= 1'b1;
    tick(3);
    chk("no_tristate", 8'h07, {5'h0, pin_oe[7:5]});
    wr(EP_OFF_PWM_TRI, 8'h07);
    tick(3);
    chk("tristate", 8'h00, {5'h0, pin_oe[7:5]});
    alt <= 1'b1;
    sd <= 1'b0;
    tick(3);
    chk("port_e", 8'h04, {4'h0, e_pins});
    chk("port_e_oe", 8'h0f, {4'h0, e_oe});
    chk("par_pins", 8'h03, {5'h0, pin_o[7:5]});
    wr(EP_OFF_DIRECTION, 8'hff);
    tick(3);
    chk("par_dir", 8'he0, pin_oe);
    par <= 5'b10000;
    ext_val <= 8'h80;
    tick(5);
    chk("slave_oe", 8'h20, pin_oe);
    chk("slave_in", 8'h01, {6'h0, rs, ws});
    $display("pin mux test done");
    par <= 5'b11110;
    do_reset(1'b1);
    for (int a = 0; a < 3; a++) begin
      rd(a[2:0], 8'h00, "small_read");
    end
    chk("small_oe", 8'h00, {5'h0, pin_oe[7:5]});
    $display("small package test done");
    summarize();
  end
endmodule
